// [coproc_completion_signalling.sv]
// Top of the coprocessor completion signalling block, with APB registers
//
// Functional notes
// - Cause codes sampled with strobe and flag.
// - Nullify strobe marks valid nullify indication.
// - Nullify flag high means instruction nullified.
// - Pipe 1 nullifies arithmetic instructions only.
// - Kill code 00 means commit allowed.
// - Kill 10 other reason, 11 own exception.
// - Reset pulses coprocessor reset one cycle.
// - Sleep only while coprocessor idle; granted regardless of idle when no coprocessor strap is set.
// - Narrow strap makes 64-bit transfers reserved.
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
module coproc_completion_signalling (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Core pipeline verdicts, pipe 0
  input  wire logic        done_valid_pipe0,
  input  wire logic        done_nullify_pipe0,
  input  wire logic        done_killed_pipe0,
  input  wire logic        done_is_transfer_pipe0,
  input  wire logic        done_wide_transfer_pipe0,
  // Core pipeline verdicts, pipe 1
  input  wire logic        done_valid_pipe1,
  input  wire logic        done_nullify_pipe1,
  input  wire logic        done_killed_pipe1,
  input  wire logic        done_is_transfer_pipe1,
  // Exceptions from coprocessor
  input  wire logic        exception_strobe_pipe0,
  input  wire logic        exception_flag_pipe0,
  input  wire logic [4:0]  exception_cause_pipe0,
  input  wire logic        exception_strobe_pipe1,
  input  wire logic        exception_flag_pipe1,
  input  wire logic [4:0]  exception_cause_pipe1,
  // Nullify and kill to coprocessor
  output logic             nullify_strobe_pipe0,
  output logic             nullify_flag_pipe0,
  output logic             nullify_strobe_pipe1,
  output logic             nullify_flag_pipe1,
  output logic             kill_strobe_pipe0,
  output logic [1:0]       kill_code_pipe0,
  output logic             kill_strobe_pipe1,
  output logic [1:0]       kill_code_pipe1,
  // Miscellaneous
  output logic             coproc_reset_pulse,
  input  wire logic        fpu_attached_strap,
  input  wire logic        media_unit_attached_strap,
  input  wire logic        second_coproc_attached_strap,
  input  wire logic        coproc_idle,
  input  wire logic        narrow_transfer_only_strap,
  output logic             sleep_granted,
  output logic             reserved_instruction_exception,
  output logic             irq
);

  // ----------------------------------------------------------------------
  // Per-pipe completion
  // ----------------------------------------------------------------------
  logic       exc_event0;
  logic       exc_event1;
  logic       cause_bad0;
  logic       cause_bad1;
  logic [4:0] cause0;
  logic [4:0] cause1;

  // Pipe 1 never nullifies transfers
  wire logic null_ok1 = !done_is_transfer_pipe1;

  coproc_pipe_completion pipe0_u (
    .sys_clk        (sys_clk),
    .reset          (reset),
    .clk_en         (clk_en),
    .done_valid     (done_valid_pipe0),
    .done_nullify   (done_nullify_pipe0),
    .done_killed    (done_killed_pipe0),
    .null_allowed   (1'b1),
    .exc_strobe     (exception_strobe_pipe0),
    .exc_flag       (exception_flag_pipe0),
    .exc_cause      (exception_cause_pipe0),
    .nullify_strobe (nullify_strobe_pipe0),
    .nullify_flag   (nullify_flag_pipe0),
    .kill_strobe    (kill_strobe_pipe0),
    .kill_code      (kill_code_pipe0),
    .exc_event      (exc_event0),
    .cause_bad      (cause_bad0),
    .cause_q        (cause0)
  );

  coproc_pipe_completion pipe1_u (
    .sys_clk        (sys_clk),
    .reset          (reset),
    .clk_en         (clk_en),
    .done_valid     (done_valid_pipe1),
    .done_nullify   (done_nullify_pipe1),
    .done_killed    (done_killed_pipe1),
    .null_allowed   (null_ok1),
    .exc_strobe     (exception_strobe_pipe1),
    .exc_flag       (exception_flag_pipe1),
    .exc_cause      (exception_cause_pipe1),
    .nullify_strobe (nullify_strobe_pipe1),
    .nullify_flag   (nullify_flag_pipe1),
    .kill_strobe    (kill_strobe_pipe1),
    .kill_code      (kill_code_pipe1),
    .exc_event      (exc_event1),
    .cause_bad      (cause_bad1),
    .cause_q        (cause1)
  );

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  logic [1:0]                                 ctrl_q;
  logic [coproc_completion_pkg::IRQ_WIDTH-1:0] irq_stat_q;
  logic [coproc_completion_pkg::IRQ_WIDTH-1:0] irq_mask_q;
  logic                                       reset_seen_q;

  wire logic acc   = psel && penable && !pready;
  wire logic wr    = acc && pwrite;
  wire logic rd    = acc && !pwrite;
  wire logic hit_ctrl = paddr == coproc_completion_pkg::ADDR_CONTROL;
  wire logic hit_stat = paddr == coproc_completion_pkg::ADDR_STATUS;
  wire logic hit_irqs = paddr == coproc_completion_pkg::ADDR_IRQ_STAT;
  wire logic hit_mask = paddr == coproc_completion_pkg::ADDR_IRQ_MASK;
  wire logic hit_caus = paddr == coproc_completion_pkg::ADDR_CAUSE;
  wire logic mapped = hit_ctrl || hit_stat || hit_irqs || hit_mask
                   || hit_caus;
  wire logic soft_reset = wr && hit_ctrl
                       && pwdata[coproc_completion_pkg::CTRL_SOFT_RESET];

  // ----------------------------------------------------------------------
  // Sleep, reserved-instruction and status
  // ----------------------------------------------------------------------
  wire logic any_present = fpu_attached_strap || media_unit_attached_strap
                        || second_coproc_attached_strap;
  wire logic sleep_d = ctrl_q[coproc_completion_pkg::CTRL_SLEEP_REQ]
                    && (!any_present || coproc_idle);
  wire logic ri_d = done_valid_pipe0 && done_is_transfer_pipe0
                 && done_wide_transfer_pipe0
                 && narrow_transfer_only_strap;
  wire logic [31:0] status_word = {26'h0000000, sleep_d, coproc_idle,
                                   narrow_transfer_only_strap,
                                   second_coproc_attached_strap,
                                   media_unit_attached_strap,
                                   fpu_attached_strap};
  wire logic [coproc_completion_pkg::IRQ_WIDTH-1:0] events =
    {ri_d, cause_bad0 || cause_bad1, exc_event1, exc_event0};
  wire logic [31:0] rdata_d =
      hit_ctrl ? {30'h00000000, ctrl_q}
    : hit_stat ? status_word
    : hit_irqs ? {28'h0000000, irq_stat_q}
    : hit_mask ? {28'h0000000, irq_mask_q}
    : hit_caus ? {17'h00000, cause1, 5'h00, cause0}
    : 32'h00000000;
  // Set wins over the read-clear so no event is lost
  wire logic [coproc_completion_pkg::IRQ_WIDTH-1:0] stat_d =
    ((rd && hit_irqs) ? '0 : irq_stat_q) | events;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      prdata       <= 32'h00000000;
      ctrl_q       <= 2'h0;
      irq_stat_q   <= '0;
      irq_mask_q   <= coproc_completion_pkg::IRQ_MASK_RESET;
      irq          <= 1'b0;
      sleep_granted <= 1'b0;
      reserved_instruction_exception <= 1'b0;
      // Kept low in reset so a long reset still yields a one-cycle pulse
      coproc_reset_pulse <= 1'b0;
      reset_seen_q <= 1'b1;
    end else if (clk_en) begin
      pready       <= acc;
      pslverr      <= acc && !mapped;
      prdata       <= rd ? rdata_d : 32'h00000000;
      if (wr && hit_ctrl) begin
        ctrl_q <= {pwdata[coproc_completion_pkg::CTRL_SLEEP_REQ], 1'b0};
      end
      if (wr && hit_mask) begin
        irq_mask_q <= pwdata[coproc_completion_pkg::IRQ_WIDTH-1:0];
      end
      irq_stat_q   <= stat_d;
      irq          <= |(stat_d & irq_mask_q);
      sleep_granted <= sleep_d;
      reserved_instruction_exception <= ri_d;
      // One pulse on the first edge after hard reset, one per soft reset
      coproc_reset_pulse <= reset_seen_q || soft_reset;
      reset_seen_q <= 1'b0;
    end
  end

endmodule // coproc_completion_signalling

// [coproc_completion_pkg.sv]
// Package of constants for the coprocessor completion signalling block
package coproc_completion_pkg;

  // ----------------------------------------------------------------------
  // Exception cause codes
  // ----------------------------------------------------------------------
  localparam logic [4:0] CAUSE_RESERVED_INSTR = 5'h0A;
  localparam logic [4:0] CAUSE_FLOATING_POINT = 5'h0F;
  localparam logic [4:0] CAUSE_IMPL_A         = 5'h10;
  localparam logic [4:0] CAUSE_IMPL_B         = 5'h11;
  localparam logic [4:0] CAUSE_COPROC2        = 5'h12;

  // ----------------------------------------------------------------------
  // Kill codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] KILL_NONE      = 2'h0;
  localparam logic [1:0] KILL_OTHER     = 2'h2;
  localparam logic [1:0] KILL_OWN_EXC   = 2'h3;

  // ----------------------------------------------------------------------
  // Register map (APB byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h0C;
  localparam logic [7:0] ADDR_CAUSE     = 8'h10;

  // Control fields
  localparam int CTRL_SOFT_RESET = 0;
  localparam int CTRL_SLEEP_REQ  = 1;

  // Interrupt status fields
  localparam int IRQ_EXC0     = 0;
  localparam int IRQ_EXC1     = 1;
  localparam int IRQ_BADCAUSE = 2;
  localparam int IRQ_RI_TX64  = 3;
  localparam int IRQ_WIDTH    = 4;

  // Reset values
  localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RESET = 4'h0;

endpackage : coproc_completion_pkg

// [coproc_pipe_completion.sv]
// One issue pipe's nullify, kill and exception completion logic
`timescale 1ns/1ps
module coproc_pipe_completion (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  // Core side completion request
  input  wire logic       done_valid,
  input  wire logic       done_nullify,
  input  wire logic       done_killed,
  input  wire logic       null_allowed,
  // Coprocessor exception report
  input  wire logic       exc_strobe,
  input  wire logic       exc_flag,
  input  wire logic [4:0] exc_cause,
  // Outputs to coprocessor
  output logic            nullify_strobe,
  output logic            nullify_flag,
  output logic            kill_strobe,
  output logic [1:0]      kill_code,
  // Exception report to core
  output logic            exc_event,
  output logic            cause_bad,
  output logic [4:0]      cause_q
);

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  wire logic exc_taken = exc_strobe && exc_flag;
  wire logic cause_ok  =
    (exc_cause == coproc_completion_pkg::CAUSE_RESERVED_INSTR)
    || (exc_cause == coproc_completion_pkg::CAUSE_FLOATING_POINT)
    || (exc_cause == coproc_completion_pkg::CAUSE_IMPL_A)
    || (exc_cause == coproc_completion_pkg::CAUSE_IMPL_B)
    || (exc_cause == coproc_completion_pkg::CAUSE_COPROC2);
  // Remember an own exception until this pipe's kill verdict is given
  logic      exc_pending_q;
  wire logic exc_pending = exc_pending_q || exc_taken;
  wire logic [1:0] kill_d = !done_killed ? coproc_completion_pkg::KILL_NONE
                          : exc_pending  ? coproc_completion_pkg::KILL_OWN_EXC
                          : coproc_completion_pkg::KILL_OTHER;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      nullify_strobe <= 1'b0;
      nullify_flag   <= 1'b0;
      kill_strobe    <= 1'b0;
      kill_code      <= coproc_completion_pkg::KILL_NONE;
      exc_event      <= 1'b0;
      cause_bad      <= 1'b0;
      cause_q        <= 5'h00;
      exc_pending_q  <= 1'b0;
    end else if (clk_en) begin
      nullify_strobe <= done_valid && null_allowed;
      nullify_flag   <= done_valid && null_allowed && done_nullify;
      kill_strobe    <= done_valid;
      kill_code      <= done_valid ? kill_d
                                   : coproc_completion_pkg::KILL_NONE;
      exc_event      <= exc_taken;
      cause_bad      <= exc_taken && !cause_ok;
      if (exc_taken) begin
        cause_q <= exc_cause;
      end
      exc_pending_q  <= done_valid ? 1'b0 : exc_pending;
    end
  end

endmodule // coproc_pipe_completion

// [coproc_completion_assertions.sv]
// Concurrent checks on the completion outputs of the coprocessor port
`timescale 1ns/1ps
module coproc_completion_assertions (
  // Clock, reset and core verdicts
  input wire logic       sys_clk, reset, clk_en,
  input wire logic       done_valid_pipe0, done_nullify_pipe0,
  input wire logic       done_killed_pipe0, done_is_transfer_pipe0,
  input wire logic       done_wide_transfer_pipe0, done_valid_pipe1,
  input wire logic       done_killed_pipe1, done_is_transfer_pipe1,
  input wire logic       exception_strobe_pipe1, exception_flag_pipe1,
  input wire logic       narrow_transfer_only_strap,
  // Outputs towards the coprocessor
  input wire logic       nullify_strobe_pipe0, nullify_flag_pipe0,
  input wire logic       nullify_strobe_pipe1, kill_strobe_pipe0,
  input wire logic       kill_strobe_pipe1, coproc_reset_pulse,
  input wire logic       reserved_instruction_exception,
  input wire logic [1:0] kill_code_pipe0, kill_code_pipe1
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  chk_null_pipe0: assert property (
    done_valid_pipe0 && clk_en |=>
    nullify_strobe_pipe0 && nullify_flag_pipe0 == $past(done_nullify_pipe0))
    else $error("nullify answer on pipe0 wrong");
  chk_null_xfer_pipe1: assert property (
    done_valid_pipe1 && done_is_transfer_pipe1 && clk_en |=>
    !nullify_strobe_pipe1 && kill_strobe_pipe1)
    else $error("pipe1 transfer got a nullify strobe");
  chk_kill_none_pipe0: assert property (
    done_valid_pipe0 && !done_killed_pipe0 && clk_en |=>
    kill_strobe_pipe0 && kill_code_pipe0 == 2'h0)
    else $error("unkilled pipe0 verdict not coded 00");
  chk_kill_own_pipe1: assert property (
    done_valid_pipe1 && done_killed_pipe1 && clk_en && !$past(done_valid_pipe1)
    && $past(exception_strobe_pipe1 && exception_flag_pipe1) |=>
    kill_strobe_pipe1 && kill_code_pipe1 == 2'h3)
    else $error("kill after own exception not coded 11");
  chk_strobe_cause: assert property (
    kill_strobe_pipe0 |-> $past(done_valid_pipe0) && $past(clk_en))
    else $error("pipe0 kill strobe without pipe0 verdict");
  chk_reset_one_cycle: assert property (
    $rose(coproc_reset_pulse) |=> !coproc_reset_pulse)
    else $error("coprocessor reset pulse longer than one cycle");
  chk_ri_narrow: assert property (
    done_valid_pipe0 && done_is_transfer_pipe0 && done_wide_transfer_pipe0
    && narrow_transfer_only_strap && clk_en |-> ##[1:2]
    reserved_instruction_exception)
    else $error("wide transfer under narrow strap not refused");
  chk_ri_quiet: assert property (
    !narrow_transfer_only_strap && !$past(narrow_transfer_only_strap, 3)
    |-> !reserved_instruction_exception)
    else $error("reserved instruction raised without narrow strap");
endmodule // coproc_completion_assertions

bind coproc_completion_signalling coproc_completion_assertions u_chk (
  .sys_clk, .reset, .clk_en, .done_valid_pipe0, .done_nullify_pipe0,
  .done_killed_pipe0, .done_is_transfer_pipe0, .done_wide_transfer_pipe0,
  .done_valid_pipe1, .done_killed_pipe1, .done_is_transfer_pipe1,
  .exception_strobe_pipe1, .exception_flag_pipe1,
  .narrow_transfer_only_strap, .nullify_strobe_pipe0, .nullify_flag_pipe0,
  .nullify_strobe_pipe1, .kill_strobe_pipe0, .kill_strobe_pipe1,
  .coproc_reset_pulse, .reserved_instruction_exception, .kill_code_pipe0,
  .kill_code_pipe1);

// [coproc_far_model.sv]
// Behavioural coprocessor that reports exceptions per pipe
`timescale 1ns/1ps
module coproc_far_model (
  // Commands from the bench
  input  wire logic       sys_clk, raise, busy,
  input  wire logic [1:0] report,
  input  wire logic [4:0] cause,
  // Exception reports and activity
  output logic            exception_strobe_pipe0, exception_flag_pipe0,
  output logic            exception_strobe_pipe1, exception_flag_pipe1,
  output logic [4:0]      exception_cause_pipe0, exception_cause_pipe1,
  output logic            coproc_idle
);
  logic [5:0] churn = 6'h00;
  // Flag and cause churn while unstrobed, so the core cannot lean on them
  always @(posedge sys_clk) begin
    churn                  <= churn + 6'h01;
    exception_strobe_pipe0 <= report[0];
    exception_flag_pipe0   <= report[0] ? raise : churn[0];
    exception_cause_pipe0  <= report[0] ? cause : churn[5:1];
    exception_strobe_pipe1 <= report[1];
    exception_flag_pipe1   <= report[1] ? raise : churn[1];
    exception_cause_pipe1  <= report[1] ? cause : churn[4:0];
    coproc_idle            <= ~busy;
  end
endmodule // coproc_far_model

// [test_coproc_completion_signalling.sv]
// Self-checking bench for the coprocessor completion signalling block
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module test_coproc_completion_signalling;
  logic sys_clk, reset, clk_en, psel, penable, pwrite, pready, pslverr;
  logic raise, busy, err, irq, sleep_granted, coproc_reset_pulse;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, r, seed;
  logic [4:0] cause, exception_cause_pipe0, exception_cause_pipe1;
  logic [1:0] report, kill_code_pipe0, kill_code_pipe1;
  logic done_valid_pipe0, done_nullify_pipe0, done_killed_pipe0;
  logic done_is_transfer_pipe0, done_wide_transfer_pipe0, done_valid_pipe1;
  logic done_nullify_pipe1, done_killed_pipe1, done_is_transfer_pipe1;
  logic exception_strobe_pipe0, exception_flag_pipe0, exception_flag_pipe1;
  logic exception_strobe_pipe1, nullify_strobe_pipe0, nullify_flag_pipe0;
  logic nullify_strobe_pipe1, nullify_flag_pipe1, kill_strobe_pipe0;
  logic kill_strobe_pipe1, fpu_attached_strap, media_unit_attached_strap;
  logic second_coproc_attached_strap, coproc_idle;
  logic narrow_transfer_only_strap, reserved_instruction_exception;
  logic [3:0] stat_exp;
  logic [4:0] cause_exp [2];
  logic [4:0] codes [5] = '{5'h0A, 5'h0F, 5'h10, 5'h11, 5'h12};
  int exc_seen [2];
  int checks, num_errors, n_rst, n_ri;
  wire [2:0] kill0 = {kill_strobe_pipe0, kill_code_pipe0};
  wire [2:0] kill1 = {kill_strobe_pipe1, kill_code_pipe1};
  wire [1:0] null0 = {nullify_strobe_pipe0, nullify_flag_pipe0};
  wire [1:0] null1 = {nullify_strobe_pipe1, nullify_flag_pipe1};

  coproc_completion_signalling dut (.*);
  coproc_far_model partner (.*);

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (!reset && coproc_reset_pulse === 1'b1) n_rst++;
    if (reserved_instruction_exception === 1'b1) n_ri++;
  end

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    for (i = 0; pready !== 1'b1; i++) begin
      if (i == 20) begin num_errors++; close_out(); end
      @(posedge sys_clk);
    end
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  task automatic rdchk(input string s, input logic [7:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(s, e, rd)
  endtask
  task automatic exc(input int p, input logic f, input logic [4:0] c);
    @(posedge sys_clk);
    {report, raise, cause} <= {2'(1 << p), f, c};
    @(posedge sys_clk);
    report <= 2'b00;
    if (f) begin
      exc_seen[p] = 1;
      {stat_exp[p], cause_exp[p]} = {1'b1, c};
    end
  endtask
  task automatic verdict(input int p, input logic k, n, t, w);
    logic [1:0] ek;
    ek = !k ? 2'h0 : (exc_seen[p] != 0) ? 2'h3 : 2'h2;
    exc_seen[p] = 0;
    @(posedge sys_clk);
    if (p == 0) {done_valid_pipe0, done_killed_pipe0, done_nullify_pipe0,
      done_is_transfer_pipe0, done_wide_transfer_pipe0} <= {1'b1, k, n, t, w};
    else {done_valid_pipe1, done_killed_pipe1, done_nullify_pipe1,
      done_is_transfer_pipe1} <= {1'b1, k, n, t};
    if (p == 0 && t && w && narrow_transfer_only_strap) stat_exp[3] = 1'b1;
    @(posedge sys_clk);
    {done_valid_pipe0, done_valid_pipe1} <= 2'b00;
    @(negedge sys_clk);
    if (p == 0) begin
      `CHK("kill pipe0", {1'b1, ek}, kill0)
      `CHK("null pipe0", {1'b1, n}, null0)
      `CHK("kill strobe pipe1", 1'b0, kill1[2])
    end else begin
      `CHK("kill pipe1", {1'b1, ek}, kill1)
      `CHK("null strobe pipe1", !t, null1[1])
      if (!t) `CHK("null flag pipe1", n, null1[0])
    end
  endtask

  initial begin
    {clk_en, reset, busy, fpu_attached_strap} = '1;
    {second_coproc_attached_strap, media_unit_attached_strap} = 2'b10;
    {psel, penable, pwrite, paddr, pwdata, report, raise, cause} = '0;
    {done_valid_pipe0, done_nullify_pipe0, done_killed_pipe0} = '0;
    {done_is_transfer_pipe0, done_wide_transfer_pipe0, done_valid_pipe1} = '0;
    {done_nullify_pipe1, done_killed_pipe1, done_is_transfer_pipe1} = '0;
    {narrow_transfer_only_strap, stat_exp, checks, num_errors} = '0;
    {n_rst, n_ri, seed} = {32'h0, 32'h0, 32'h00009917};
    exc_seen = '{0, 0};
    cause_exp = '{5'h00, 5'h00};
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    `CHK("reset pulse quiet", 1'b0, coproc_reset_pulse)
    repeat (3) @(posedge sys_clk);
    `CHK("reset pulse count", 1, n_rst)
    rdchk("mask reset", coproc_completion_pkg::ADDR_IRQ_MASK, 32'h0);
    rdchk("straps", coproc_completion_pkg::ADDR_STATUS, 32'h5);
    apb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped read", 33'h100000000, {err, rd})
    $display("test reset and registers done");
    repeat (80) begin
      r = rnd();
      if (r[0]) exc(int'(r[1]), r[2], codes[r[10:8] % 5]);
      verdict(int'(r[3]), r[4], r[5], r[6], r[7]);
    end
    rdchk("irq status", coproc_completion_pkg::ADDR_IRQ_STAT, 32'(stat_exp));
    rdchk("irq status clear", coproc_completion_pkg::ADDR_IRQ_STAT, 32'h0);
    rdchk("causes", coproc_completion_pkg::ADDR_CAUSE,
          {17'h0, cause_exp[1], 5'h0, cause_exp[0]});
    $display("test random verdicts done");
    exc(0, 1'b1, 5'h0F);
    repeat (3) @(negedge sys_clk);
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, coproc_completion_pkg::ADDR_IRQ_MASK, 32'hF);
    repeat (2) @(negedge sys_clk);
    `CHK("irq raised", 1'b1, irq)
    rdchk("irq read", coproc_completion_pkg::ADDR_IRQ_STAT, 32'h1);
    repeat (2) @(negedge sys_clk);
    `CHK("irq cleared", 1'b0, irq)
    $display("test interrupt done");
    @(posedge sys_clk);
    narrow_transfer_only_strap <= 1'b1;
    verdict(0, 1'b0, 1'b0, 1'b1, 1'b1);
    verdict(0, 1'b0, 1'b0, 1'b1, 1'b0);
    verdict(1, 1'b0, 1'b0, 1'b1, 1'b0);
    repeat (3) @(posedge sys_clk);
    narrow_transfer_only_strap <= 1'b0;
    `CHK("ri pulses", 1, n_ri)
    rdchk("ri status", coproc_completion_pkg::ADDR_IRQ_STAT, 32'h8);
    n_rst = 0;
    apb(1'b1, coproc_completion_pkg::ADDR_CONTROL, 32'h1);
    repeat (4) @(posedge sys_clk);
    `CHK("soft reset pulse", 1, n_rst)
    apb(1'b1, coproc_completion_pkg::ADDR_CONTROL, 32'h2);
    repeat (3) @(negedge sys_clk);
    `CHK("sleep while busy", 1'b0, sleep_granted)
    @(posedge sys_clk);
    busy <= 1'b0;
    repeat (4) @(negedge sys_clk);
    `CHK("sleep when idle", 1'b1, sleep_granted)
    @(posedge sys_clk);
    {clk_en, done_valid_pipe0} <= 2'b01;
    @(posedge sys_clk);
    {clk_en, done_valid_pipe0} <= 2'b10;
    @(negedge sys_clk);
    `CHK("frozen kill strobe", 1'b0, kill_strobe_pipe0)
    $display("test strap, reset and sleep done");
    close_out();
  end
endmodule // test_coproc_completion_signalling
